// >>> sim/tb_perf_cycle_counter_axi_monitor_select.sv
// self-checking testbench of the cycle counter and axi monitor select block
`timescale 1ns/1ps
`include "pcc_consts.svh"
module tb_perf_cycle_counter_axi_monitor_select import pcc_pkg::*;;
  logic            ref_clk = 1'b0;
  logic            rst = 1'b1;
  pcc_bus_req_t    busReq = '0;
  logic [31:0]     rdata;
  logic [15:0]     classBeat = '0;
  logic [3:0][7:0] queueDepth = '0;
  logic            bwEvent;
  logic [7:0]      latencyMax;
  logic [3:0]      trafficClass;
  logic [1:0]      latencySel;
  logic            bwFilterEn;
  logic            irq;
  int              mismatches = 0;
  int              total_checks = 0;
  logic [31:0]     rv;
  logic [31:0]     rw;
  logic [3:0]      codes [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'h9};

  always #12.5 ref_clk = ~ref_clk;

  pcc_perf_monitor #(.QW(8)) dut (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .busReq       (busReq),
    .rdata        (rdata),
    .classBeat    (classBeat),
    .queueDepth   (queueDepth),
    .bwEvent      (bwEvent),
    .latencyMax   (latencyMax),
    .trafficClass (trafficClass),
    .latencySel   (latencySel),
    .bwFilterEn   (bwFilterEn),
    .irq          (irq)
  );

  task automatic results();
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      mismatches++;
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    busReq <= '0;
    @(posedge ref_clk);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    busReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    busReq <= '0;
    #1 d = rdata;
    @(posedge ref_clk);
  endtask

  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic beat(input logic [15:0] v, input logic e);
    classBeat <= v;
    @(posedge ref_clk);
    #1 chk({31'h0, bwEvent}, {31'h0, e}, "bandwidth event");
    @(posedge ref_clk);
  endtask

  task automatic t_reset();
    chk({25'h0, bwFilterEn, latencySel, trafficClass}, 32'h0, "selector outputs");
    rd_reg(`PCC_OFS_CNT_HI, rv);
    chk(rv, 32'h0, "high word at reset");
    rd_reg(`PCC_OFS_CNT_LO, rv);
    chk({8'h0, rv[31:8]}, 32'h0, "low word at reset");
    rd_reg(`PCC_OFS_CHAN, rv);
    chk(rv, 32'h0, "channel select at reset");
    rd_reg(`PCC_OFS_INT_SET, rv);
    chk(rv, 32'h0, "overflow enable at reset");
    rd_reg(`PCC_OFS_CTRL, rv);
    chk(rv, 32'h1, "count enable at reset");
  endtask

  task automatic t_count();
    rd_reg(`PCC_OFS_CNT_LO, rv);
    rd_reg(`PCC_OFS_CNT_LO, rw);
    chk(rw - rv, 32'h2, "count advance over two cycles");
    wr_reg(`PCC_OFS_CNT_LO, 32'h12345678);
    rd_reg(`PCC_OFS_CNT_LO, rv);
    chk(rv, 32'h12345679, "low word after write");
    wr_reg(`PCC_OFS_CNT_HI, 32'hffff1234);
    rd_reg(`PCC_OFS_CNT_HI, rv);
    chk(rv, 32'h00001234, "high word reserved bits");
  endtask

  task automatic t_chan();
    wr_reg(`PCC_OFS_CHAN, 32'hffffffff);
    rd_reg(`PCC_OFS_CHAN, rv);
    chk(rv, 32'h0000070f, "channel select readback");
    chk({25'h0, bwFilterEn, latencySel, trafficClass}, 32'h7f, "selector outputs");
    wr_reg(8'h20, 32'hffffffff);
    rd_reg(8'h20, rv);
    chk(rv, 32'h0, "unmapped read");
  endtask

  task automatic t_bw();
    wr_reg(`PCC_OFS_CHAN, 32'h0);
    beat(16'h0200, 1'b1);
    beat(16'h0000, 1'b0);
    foreach (codes[i]) begin
      wr_reg(`PCC_OFS_CHAN, {21'h0, 1'b1, 6'h0, codes[i]});
      beat(16'h0001 << codes[i], 1'b1);
      beat(~(16'h0001 << codes[i]), 1'b0);
    end
  endtask

  task automatic t_lat();
    queueDepth <= {8'h40, 8'h30, 8'h20, 8'h10};
    for (int s = 0; s < 4; s++) begin
      wr_reg(`PCC_OFS_CHAN, s << 8);
      settle();
      chk({24'h0, latencyMax}, (s + 1) * 16, "selected queue maximum");
      chk({30'h0, latencySel}, s, "latency select output");
    end
    queueDepth[3] <= 8'h50;
    settle();
    queueDepth[3] <= 8'h05;
    settle();
    chk({24'h0, latencyMax}, 32'h50, "maximum held after drop");
  endtask

  task automatic t_irq();
    wr_reg(`PCC_OFS_CNT_HI, 32'h0000ffff);
    wr_reg(`PCC_OFS_CNT_LO, 32'hffffffff);
    settle();
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd_reg(`PCC_OFS_STATUS, rv);
    chk(rv, 32'h80000000, "overflow status");
    rd_reg(`PCC_OFS_CNT_HI, rv);
    chk(rv, 32'h0, "high word after wrap");
    wr_reg(`PCC_OFS_INT_SET, 32'h80000000);
    settle();
    chk({31'h0, irq}, 32'h1, "irq enabled");
    rd_reg(`PCC_OFS_INT_SET, rv);
    chk(rv, 32'h80000000, "enable via set register");
    rd_reg(`PCC_OFS_INT_CLR, rv);
    chk(rv, 32'h80000000, "enable via clear register");
    wr_reg(`PCC_OFS_INT_CLR, 32'h80000000);
    settle();
    chk({31'h0, irq}, 32'h0, "irq after enable clear");
    rd_reg(`PCC_OFS_INT_SET, rv);
    chk(rv, 32'h0, "enable cleared");
    wr_reg(`PCC_OFS_STAT_CLR, 32'h80000000);
    rd_reg(`PCC_OFS_STATUS, rv);
    chk(rv, 32'h0, "status cleared");
    wr_reg(`PCC_OFS_INT_SET, 32'h80000000);
    settle();
    chk({31'h0, irq}, 32'h0, "irq without status");
    // wrap lands on the status clear strobe
    wr_reg(`PCC_OFS_CNT_HI, 32'h0000ffff);
    wr_reg(`PCC_OFS_CNT_LO, 32'hfffffffe);
    wr_reg(`PCC_OFS_STAT_CLR, 32'h80000000);
    settle();
    chk({31'h0, irq}, 32'h1, "wrap beats status clear");
    rd_reg(`PCC_OFS_STATUS, rv);
    chk(rv, 32'h80000000, "status kept by wrap");
    wr_reg(`PCC_OFS_STAT_CLR, 32'h80000000);
    settle();
    chk({31'h0, irq}, 32'h0, "irq after status clear");
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_count();
    t_chan();
    t_bw();
    t_lat();
    t_irq();
    results();
  end

  // hang guard, far beyond the under two hundred cycles of the sequence
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    results();
  end
endmodule

// >>> verilog/pcc_consts.svh
// register offsets, field positions and reset values of the cycle counter block
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH
`define PCC_OFS_CNT_LO   8'h00
`define PCC_OFS_CNT_HI   8'h04
`define PCC_OFS_CHAN     8'h08
`define PCC_OFS_INT_SET  8'h0c
`define PCC_OFS_INT_CLR  8'h10
`define PCC_OFS_STATUS   8'h14
`define PCC_OFS_STAT_CLR 8'h18
`define PCC_OFS_CTRL     8'h1c
`define PCC_BIT_BW_EN    10
`define PCC_MSB_LAT_SEL  9
`define PCC_LSB_LAT_SEL  8
`define PCC_MSB_CLASS    3
`define PCC_BIT_OVF      31
`define PCC_BIT_CNT_EN   0
`define PCC_RST_CNT      48'h000000000000
`define PCC_RST_CHAN     4'h0
`define PCC_RST_CNT_EN   1'b1
`define PCC_CNT_MAX      48'hffffffffffff
`define PCC_QW           8
`endif

// >>> verilog/pcc_perf_monitor.sv
// cycle counter, axi monitor channel select and overflow interrupt
`timescale 1ns/1ps
`include "pcc_consts.svh"

module pcc_perf_monitor import pcc_pkg::*; #(
  parameter int QW = `PCC_QW
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // register port
  input  wire pcc_bus_req_t      busReq,
  output logic [31:0]            rdata,
  // traffic observation
  input  wire logic [15:0]       classBeat,
  input  wire logic [3:0][QW-1:0] queueDepth,
  // monitor outputs
  output logic                   bwEvent,
  output logic [QW-1:0]          latencyMax,
  output logic [3:0]             trafficClass,
  output logic [1:0]             latencySel,
  output logic                   bwFilterEn,
  // interrupt
  output logic                   irq
);

  pcc_state_t st_reg;
  pcc_state_t st_next;

  logic wrLo;
  logic wrHi;
  logic wrChan;
  logic wrSet;
  logic wrClr;
  logic wrStatClr;
  logic wrCtrl;
  logic wrap;
  logic [3:0][QW-1:0] qMaxNext;

  assign wrLo      = busReq.wr && busReq.addr == `PCC_OFS_CNT_LO;
  assign wrHi      = busReq.wr && busReq.addr == `PCC_OFS_CNT_HI;
  assign wrChan    = busReq.wr && busReq.addr == `PCC_OFS_CHAN;
  assign wrSet     = busReq.wr && busReq.addr == `PCC_OFS_INT_SET;
  assign wrClr     = busReq.wr && busReq.addr == `PCC_OFS_INT_CLR;
  assign wrStatClr = busReq.wr && busReq.addr == `PCC_OFS_STAT_CLR;
  assign wrCtrl    = busReq.wr && busReq.addr == `PCC_OFS_CTRL;
  assign wrap      = st_reg.countEn && st_reg.cnt == `PCC_CNT_MAX;

  // per-queue high-water mark, restarted when the selector is rewritten
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_queue
      always_comb begin
        if (wrChan) begin
          qMaxNext[gi] = queueDepth[gi];
        end else if (queueDepth[gi] > st_reg.qMax[gi]) begin
          qMaxNext[gi] = queueDepth[gi];
        end else begin
          qMaxNext[gi] = st_reg.qMax[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    st_next = st_reg;
    // counter advance and wrap
    if (st_reg.countEn) begin
      st_next.cnt = wrap ? `PCC_RST_CNT : st_reg.cnt + 48'h000000000001;
    end
    if (wrLo) begin
      st_next.cnt[31:0] = busReq.wdata;
    end
    if (wrHi) begin
      st_next.cnt[47:32] = busReq.wdata[15:0];
    end
    if (wrCtrl) begin
      st_next.countEn = busReq.wdata[`PCC_BIT_CNT_EN];
    end
    // channel select
    if (wrChan) begin
      st_next.trafficClass = busReq.wdata[`PCC_MSB_CLASS:0];
      st_next.latencySel   = busReq.wdata[`PCC_MSB_LAT_SEL:`PCC_LSB_LAT_SEL];
      st_next.bwFilterEn   = busReq.wdata[`PCC_BIT_BW_EN];
    end
    // overflow enable shares one bit between set and clear views
    if (wrSet && busReq.wdata[`PCC_BIT_OVF]) begin
      st_next.ovfIrqEn = 1'b1;
    end else if (wrClr && busReq.wdata[`PCC_BIT_OVF]) begin
      st_next.ovfIrqEn = 1'b0;
    end
    // sticky overflow, a wrap in the clear cycle wins
    if (wrap) begin
      st_next.ovfStatus = 1'b1;
    end else if (wrStatClr && busReq.wdata[`PCC_BIT_OVF]) begin
      st_next.ovfStatus = 1'b0;
    end
    st_next.irq = st_reg.ovfStatus && st_reg.ovfIrqEn;
    // bandwidth events for all classes or the selected one
    if (st_reg.bwFilterEn) begin
      st_next.bwEvent = classBeat[st_reg.trafficClass];
    end else begin
      st_next.bwEvent = |classBeat;
    end
    st_next.qMax       = qMaxNext;
    st_next.latencyMax = st_reg.qMax[st_reg.latencySel];
    // read data stands only in the cycle after the strobe
    st_next.rdata = 32'h00000000;
    if (busReq.rd) begin
      case (busReq.addr)
        `PCC_OFS_CNT_LO: st_next.rdata = st_reg.cnt[31:0];
        `PCC_OFS_CNT_HI: st_next.rdata = {16'h0000, st_reg.cnt[47:32]};
        `PCC_OFS_CHAN: begin
          st_next.rdata[`PCC_MSB_CLASS:0]                   = st_reg.trafficClass;
          st_next.rdata[`PCC_MSB_LAT_SEL:`PCC_LSB_LAT_SEL] = st_reg.latencySel;
          st_next.rdata[`PCC_BIT_BW_EN]                     = st_reg.bwFilterEn;
        end
        `PCC_OFS_INT_SET,
        `PCC_OFS_INT_CLR: st_next.rdata[`PCC_BIT_OVF] = st_reg.ovfIrqEn;
        `PCC_OFS_STATUS: st_next.rdata[`PCC_BIT_OVF] = st_reg.ovfStatus;
        `PCC_OFS_CTRL: st_next.rdata[`PCC_BIT_CNT_EN] = st_reg.countEn;
        default: st_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg              <= '0;
      st_reg.cnt          <= `PCC_RST_CNT;
      st_reg.trafficClass <= `PCC_RST_CHAN;
      st_reg.latencySel   <= 2'h0;
      st_reg.bwFilterEn   <= 1'b0;
      st_reg.countEn      <= `PCC_RST_CNT_EN;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata        = st_reg.rdata;
  assign bwEvent      = st_reg.bwEvent;
  assign latencyMax   = st_reg.latencyMax;
  assign trafficClass = st_reg.trafficClass;
  assign latencySel   = st_reg.latencySel;
  assign bwFilterEn   = st_reg.bwFilterEn;
  assign irq          = st_reg.irq;

  // checks
  logic [47:0] cntPlusOne;
  assign cntPlusOne = st_reg.cnt + 48'h000000000001;

  sequence s_wrap_edge;
    wrap && !wrLo && !wrHi && !wrCtrl;
  endsequence

  sequence s_wrapped;
    st_reg.cnt == `PCC_RST_CNT && st_reg.ovfStatus;
  endsequence

  property p_read_low;
    @(posedge ref_clk) disable iff (rst)
      busReq.rd && busReq.addr == `PCC_OFS_CNT_LO |=> rdata == $past(st_reg.cnt[31:0]);
  endproperty
  a_read_low: assert property (p_read_low) else $error("low count readback wrong");

  property p_read_high;
    @(posedge ref_clk) disable iff (rst)
      busReq.rd && busReq.addr == `PCC_OFS_CNT_HI |=> rdata == {16'h0000, $past(st_reg.cnt[47:32])};
  endproperty
  a_read_high: assert property (p_read_high) else $error("high count readback wrong");

  property p_reset_values;
    @(posedge ref_clk)
      $past(rst) && !rst |-> st_reg.cnt == `PCC_RST_CNT && st_reg.trafficClass == 4'h0
                             && st_reg.latencySel == 2'h0 && !st_reg.bwFilterEn;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_bw_filter;
    @(posedge ref_clk) disable iff (rst)
      st_reg.bwFilterEn |=> bwEvent == $past(classBeat[st_reg.trafficClass]);
  endproperty
  a_bw_filter: assert property (p_bw_filter) else $error("filtered bandwidth event wrong");

  property p_bw_all;
    @(posedge ref_clk) disable iff (rst)
      !st_reg.bwFilterEn |=> bwEvent == $past(|classBeat);
  endproperty
  a_bw_all: assert property (p_bw_all) else $error("unfiltered bandwidth event wrong");

  property p_lat_select;
    @(posedge ref_clk) disable iff (rst)
      wrChan ##1 1'b1 |=> latencyMax == $past(queueDepth[busReq.wdata[9:8]], 2);
  endproperty
  a_lat_select: assert property (p_lat_select) else $error("latency queue select wrong");

  property p_chan_write;
    @(posedge ref_clk) disable iff (rst)
      wrChan |=> trafficClass == $past(busReq.wdata[3:0]) && bwFilterEn == $past(busReq.wdata[10]);
  endproperty
  a_chan_write: assert property (p_chan_write) else $error("channel select write lost");

  property p_qmax_hold;
    @(posedge ref_clk) disable iff (rst)
      !wrChan |=> st_reg.qMax[0] >= $past(st_reg.qMax[0]) && st_reg.qMax[0] >= $past(queueDepth[0]);
  endproperty
  a_qmax_hold: assert property (p_qmax_hold) else $error("queue maximum not tracked");

  property p_irq_set;
    @(posedge ref_clk) disable iff (rst)
      wrSet && busReq.wdata[31] |=> st_reg.ovfIrqEn;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("overflow enable not set");

  property p_irq_clr;
    @(posedge ref_clk) disable iff (rst)
      wrClr && busReq.wdata[31] |=> !st_reg.ovfIrqEn;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("overflow enable not cleared");

  property p_count_step;
    @(posedge ref_clk) disable iff (rst)
      st_reg.countEn && !wrap && !wrLo && !wrHi |=> st_reg.cnt == $past(cntPlusOne);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not advance");

  property p_wrap_irq;
    @(posedge ref_clk) disable iff (rst)
      s_wrap_edge ##0 st_reg.ovfIrqEn && !wrClr |=> s_wrapped ##1 irq;
  endproperty
  a_wrap_irq: assert property (p_wrap_irq) else $error("wrap did not raise overflow");

  property p_read_idle;
    @(posedge ref_clk) disable iff (rst)
      !busReq.rd |=> rdata == 32'h00000000;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not idle");

  property p_read_chan;
    @(posedge ref_clk) disable iff (rst)
      busReq.rd && busReq.addr == `PCC_OFS_CHAN |=> rdata == {21'h0, $past(st_reg.bwFilterEn), $past(st_reg.latencySel), 4'h0, $past(st_reg.trafficClass)};
  endproperty
  a_read_chan: assert property (p_read_chan) else $error("channel select readback wrong");

  property p_read_enable;
    @(posedge ref_clk) disable iff (rst)
      busReq.rd && (busReq.addr == `PCC_OFS_INT_SET || busReq.addr == `PCC_OFS_INT_CLR) |=> rdata == {$past(st_reg.ovfIrqEn), 31'h0};
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("overflow enable readback wrong");

  property p_write_low;
    @(posedge ref_clk) disable iff (rst)
      wrLo |=> st_reg.cnt[31:0] == $past(busReq.wdata);
  endproperty
  a_write_low: assert property (p_write_low) else $error("low count write lost");

  property p_write_high;
    @(posedge ref_clk) disable iff (rst)
      wrHi |=> st_reg.cnt[47:32] == $past(busReq.wdata[15:0]);
  endproperty
  a_write_high: assert property (p_write_high) else $error("high count write lost");

  property p_wrap_status;
    @(posedge ref_clk) disable iff (rst)
      s_wrap_edge |=> s_wrapped;
  endproperty
  a_wrap_status: assert property (p_wrap_status) else $error("wrap did not set overflow status");

  property p_irq_gated;
    @(posedge ref_clk) disable iff (rst)
      irq |-> $past(st_reg.ovfIrqEn) && $past(st_reg.ovfStatus);
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("irq without enabled overflow");

  property p_enable_hold;
    @(posedge ref_clk) disable iff (rst)
      !wrSet && !wrClr |=> st_reg.ovfIrqEn == $past(st_reg.ovfIrqEn);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("overflow enable changed unasked");

  property p_chan_hold;
    @(posedge ref_clk) disable iff (rst)
      !wrChan |=> $stable(trafficClass) && $stable(latencySel) && $stable(bwFilterEn);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel select changed unasked");

  property p_qmax_restart;
    @(posedge ref_clk) disable iff (rst)
      wrChan |=> st_reg.qMax == $past(queueDepth);
  endproperty
  a_qmax_restart: assert property (p_qmax_restart) else $error("queue maxima not restarted");

endmodule

// >>> verilog/pcc_pkg.sv
// types of the cycle counter and axi monitor select block
package pcc_pkg;
  `include "pcc_consts.svh"

  typedef enum logic [3:0] {
    PCC_TC_COMMAND      = 4'h0,
    PCC_TC_INPUT_FMAP   = 4'h1,
    PCC_TC_WEIGHTS      = 4'h2,
    PCC_TC_SCALE_BIAS   = 4'h3,
    PCC_TC_MEM2MEM_RD   = 4'h4,
    PCC_TC_OUTPUT_FMAP  = 4'h8,
    PCC_TC_MEM2MEM_WR   = 4'h9
  } pcc_traffic_class_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pcc_bus_req_t;

  typedef struct packed {
    logic [47:0]                 cnt;
    logic                        countEn;
    logic [3:0]                  trafficClass;
    logic [1:0]                  latencySel;
    logic                        bwFilterEn;
    logic                        ovfIrqEn;
    logic                        ovfStatus;
    logic [31:0]                 rdata;
    logic                        irq;
    logic                        bwEvent;
    logic [3:0][`PCC_QW-1:0]     qMax;
    logic [`PCC_QW-1:0]          latencyMax;
  } pcc_state_t;
endpackage
